// >>> rtl/ecr_pkg.sv
package ecr_pkg;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int SELF_TEST_TIME_MS = 1000;
  localparam int SELF_TEST_CYCLES = CLK_HZ / 1000 * SELF_TEST_TIME_MS;
  // bus
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam logic [31:0] OFS_STREAM_DATA = 32'h01C0_0000;
  localparam logic [31:0] OFS_STREAM_SRC = 32'h01C0_0100;
  localparam logic [31:0] OFS_STREAM_DST = 32'h01C0_0200;
  localparam logic [31:0] OFS_COUNTERS = 32'h01C0_0300;
  localparam logic [31:0] OFS_SELF_TEST = 32'h01C0_0800;
  localparam logic [31:0] OFS_CONTROL = 32'h01C0_0A00;
  localparam logic [31:0] OFS_STATUS = 32'h01C0_0B00;
  localparam logic [31:0] OFS_RESET = 32'h01C0_0C00;
  localparam logic [31:0] OFS_ERROR = 32'h01C0_0E00;
  localparam logic [31:0] OFS_IDENT = 32'h01C0_0F00;
  localparam int DWORD_LSB = 3;
  localparam int PAGE_LSB = 8;
  // block transfer
  localparam int DW_SEL_W = 3;
  localparam int BLOCK_DWORDS = 4;
  localparam int BLK_IDX_W = 2;
  localparam int BT_RDY = 63;
  localparam int BT_C = 36;
  localparam int BT_PA_LSB = 5;
  localparam int BT_PA_W = 31;
  localparam int SUBBLK_IDX_W = 2;
  // counters
  localparam int CNT_W = 32;
  localparam int CNT_FREEZE = 31;
  // control
  localparam int CTL_RC = 9;
  localparam int CTL_PF = 5;
  localparam int CTL_MC = 4;
  localparam int CTL_PE = 3;
  localparam int CTL_CE = 2;
  localparam logic CTL_MC_RESET = 1'b1;
  // status
  localparam int ST_SXP = 39;
  localparam int ST_SM = 38;
  localparam int ST_NCS_LSB = 8;
  localparam int ST_SPC_LSB = 4;
  localparam int ST_WP = 2;
  localparam int ST_RP = 1;
  localparam int ST_PP = 0;
  localparam int PEND_W = 4;
  // reset flags
  localparam int RST_WD = 2;
  localparam int RST_SI = 1;
  // error capture
  localparam int ER_ME = 63;
  localparam int ER_CC = 61;
  localparam int ER_VP = 60;
  localparam int ER_CP = 59;
  localparam int ER_AE = 58;
  localparam int ER_EV = 57;
  localparam int ER_OP_LSB = 47;
  localparam int OP_W = 10;
  localparam int ER_CODE_LSB = 39;
  localparam int CODE_W = 8;
  localparam int ACK_W = 3;
  localparam int ER_S = 38;
  localparam int PA_W = 36;
  localparam int SYNC_FAULT_STATUS_W = 32;
  localparam int SYNC_FAULT_STATUS_VP = 13;
  // identity
  localparam int ID_MID_LSB = 24;
  localparam int MID_W = 4;
  localparam int ID_DEV_LSB = 8;
  localparam int ID_REV_LSB = 4;
  localparam int SIG_W = 31;

  typedef enum logic {ECR_IDLE, ECR_WAIT} ecr_host_e;

  // per-byte parity, byte i gives bit i; even=1 gives even parity
  function automatic logic [7:0] ecr_par8(input logic [63:0] d, input logic even);
    logic [7:0] p;
    p = '0;
    for (int i = 0; i < 8; i++) begin
      p[i] = (^d[i*8 +: 8]) ^ ~even;
    end
    return p;
  endfunction
endpackage

// >>> rtl/ecr_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ecr_bus_if;
  import ecr_pkg::*;
  logic req;
  logic we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic ack;
  modport host (output req, output we, output addr, output wdata, input rdata, input ack);
  modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
endinterface
`default_nettype wire

// >>> rtl/ecr_dev.sv
`timescale 1ns/1ps
`default_nettype none
module ecr_dev #(
  parameter int SELF_TEST_LEN = ecr_pkg::SELF_TEST_CYCLES,
  parameter logic [7:0] DEVICE_NUMBER = 8'h3C,  // arbitrary value
  parameter logic [3:0] REVISION_NUMBER = 4'h7, // arbitrary value
  parameter logic [3:0] VENDOR_NUMBER = 4'hA    // arbitrary value
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  ecr_bus_if.dev BUS,
  output logic STREAM_READ_REQ,
  output logic STREAM_WRITE_REQ,
  output logic [ecr_pkg::BT_PA_W-1:0] STREAM_SRC_ADDR,
  output logic STREAM_SRC_CACHEABLE,
  output logic [ecr_pkg::BT_PA_W-1:0] STREAM_DST_ADDR,
  output logic STREAM_DST_CACHEABLE,
  output logic [ecr_pkg::BLOCK_DWORDS*ecr_pkg::DATA_W-1:0] STREAM_BLOCK,
  input wire logic STREAM_FILL_VALID,
  input wire logic [ecr_pkg::BLK_IDX_W-1:0] STREAM_FILL_INDEX,
  input wire logic [ecr_pkg::DATA_W-1:0] STREAM_FILL_DATA,
  input wire logic STREAM_READ_DONE,
  input wire logic STREAM_WRITE_DONE,
  input wire logic CACHE_REF,
  input wire logic CACHE_MISS,
  input wire logic REF_IS_READ,
  input wire logic BURST_READ_MISS,
  input wire logic [ecr_pkg::BT_PA_W-1:0] MISS_SUBBLK_ADDR,
  input wire logic NEXT_SUBBLK_PRESENT,
  input wire logic PREFETCH_DONE,
  output logic PREFETCH_REQ,
  output logic [ecr_pkg::BT_PA_W-1:0] PREFETCH_ADDR,
  output logic READ_ONLY_COUNTING,
  output logic PREFETCH_ENABLE,
  output logic MULTI_COMMAND_ENABLE,
  output logic PARITY_EVEN_CHECK,
  output logic CACHE_ENABLE,
  input wire logic [ecr_pkg::DATA_W-1:0] WR_DATA,
  output logic [7:0] WR_PARITY,
  input wire logic RD_VALID,
  input wire logic [ecr_pkg::DATA_W-1:0] RD_DATA,
  input wire logic [7:0] RD_PARITY,
  input wire logic STORE_EXCEPTION_PENDING,
  input wire logic SYNCHRONOUS_SPEED,
  input wire logic [ecr_pkg::PEND_W-1:0] NONCACHE_STORE_PENDING_COUNT,
  input wire logic [ecr_pkg::PEND_W-1:0] STORE_PENDING_COUNT,
  input wire logic WRITE_MISS_PENDING,
  input wire logic READ_MISS_PENDING,
  input wire logic WATCHDOG_RESET,
  output logic SOFT_RESET,
  input wire logic CONSISTENCY_ERROR,
  input wire logic MASTER_WRITE_PARITY_ERROR,
  input wire logic ASYNCHRONOUS_ERROR,
  input wire logic [ecr_pkg::ACK_W-1:0] ERR_BUS_ACK,
  input wire logic [ecr_pkg::OP_W-1:0] ERR_OPERATION_CODE,
  input wire logic ERR_SUPERVISOR,
  input wire logic [ecr_pkg::PA_W-1:0] ERR_ADDR,
  output logic MODULE_ERROR,
  output logic [ecr_pkg::SYNC_FAULT_STATUS_W-1:0] SYNC_FAULT_STATUS,
  output logic [ecr_pkg::PA_W-1:0] SYNC_FAULT_ADDRESS,
  input wire logic [ecr_pkg::MID_W-1:0] MODULE_ID
);
  import ecr_pkg::*;

  if (SELF_TEST_LEN < 1) begin : g_chk
    $error("SELF_TEST_LEN must be at least one cycle");
  end

  typedef struct packed {
    logic [BT_PA_W-1:0] src_addr;
    logic src_c;
    logic src_rdy;
    logic [BT_PA_W-1:0] dst_addr;
    logic dst_c;
    logic dst_rdy;
    logic [BLOCK_DWORDS-1:0][DATA_W-1:0] blk;
    logic rd_req;
    logic wr_req;
    logic [CNT_W-1:0] miss_count;
    logic [CNT_W-1:0] ref_count;
    logic read_only_counting;
    logic prefetch_enable;
    logic multi_command_enable;
    logic parity_even_check;
    logic cache_enable;
    logic watchdog_reset_flag;
    logic soft_reset;
    logic multiple_error;
    logic consistency_error;
    logic master_write_parity_error;
    logic read_parity_error;
    logic asynchronous_error;
    logic error_valid;
    logic [OP_W-1:0] operation_code;
    logic [CODE_W-1:0] err_code;
    logic err_super;
    logic [PA_W-1:0] err_addr;
    logic sync_fault_status_vp;
    logic [PA_W-1:0] sync_fault_address;
    logic pf_req;
    logic pf_pend;
    logic [BT_PA_W-1:0] pf_addr;
    logic self_test_busy;
    logic [31:0] self_test_cnt;
    logic [SIG_W-1:0] signature;
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic [7:0] wr_par;
  } ecr_dev_s;

  ecr_dev_s st_ff;
  ecr_dev_s nxt_st;

  logic take;
  logic [DATA_W-1:0] rd_val;
  logic [7:0] syndrome;
  logic cp_in;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_req = 1'b0;
    nxt_st.wr_req = 1'b0;
    nxt_st.pf_req = 1'b0;
    nxt_st.ack = 1'b0;
    take = BUS.req && !st_ff.ack && !st_ff.self_test_busy;
    rd_val = '0;
    // odd mode leaves checking off so a forced bad parity is never reported
    syndrome = ecr_par8(RD_DATA, 1'b1) ^ RD_PARITY;
    cp_in = RD_VALID && st_ff.parity_even_check && (|syndrome);
    nxt_st.wr_par = ecr_par8(WR_DATA, st_ff.parity_even_check);

    // hardware events before bus writes: completions, counts, prefetch
    if (STREAM_FILL_VALID) begin
      nxt_st.blk[STREAM_FILL_INDEX] = STREAM_FILL_DATA;
    end
    if (STREAM_READ_DONE) begin
      nxt_st.src_rdy = 1'b1;
    end
    if (STREAM_WRITE_DONE) begin
      nxt_st.dst_rdy = 1'b1;
    end
    if (!st_ff.ref_count[CNT_FREEZE]) begin
      if (CACHE_REF && (!st_ff.read_only_counting || REF_IS_READ)) begin
        nxt_st.ref_count = st_ff.ref_count + 1'b1;
      end
      if (CACHE_MISS && (!st_ff.read_only_counting || REF_IS_READ)) begin
        nxt_st.miss_count = st_ff.miss_count + 1'b1;
      end
    end
    if (PREFETCH_DONE) begin
      nxt_st.pf_pend = 1'b0;
    end
    if (BURST_READ_MISS && st_ff.prefetch_enable && !NEXT_SUBBLK_PRESENT && !st_ff.pf_pend
        && (MISS_SUBBLK_ADDR[SUBBLK_IDX_W-1:0] != '1)) begin
      nxt_st.pf_req = 1'b1;
      nxt_st.pf_pend = 1'b1;
      nxt_st.pf_addr = MISS_SUBBLK_ADDR + 1'b1;
    end

    // self-test runs with the bus answer withheld, which stalls the processor
    if (st_ff.self_test_busy) begin
      nxt_st.signature = {st_ff.signature[SIG_W-2:0],
                          st_ff.signature[SIG_W-1] ^ st_ff.signature[2]};
      nxt_st.self_test_cnt = st_ff.self_test_cnt - 1'b1;
      if (st_ff.self_test_cnt == '0) begin
        nxt_st.self_test_busy = 1'b0;
        nxt_st.ack = 1'b1;
      end
    end

    if (take) begin
      nxt_st.ack = 1'b1;
      if (BUS.addr[ADDR_W-1:PAGE_LSB] == OFS_STREAM_DATA[ADDR_W-1:PAGE_LSB]) begin
        // only the dword select matters here; other offset bits are don't-care
        rd_val = st_ff.blk[BUS.addr[DWORD_LSB +: BLK_IDX_W]];
        if (BUS.we) begin
          nxt_st.blk[BUS.addr[DWORD_LSB +: BLK_IDX_W]] = BUS.wdata;
        end
      end else if (BUS.addr[ADDR_W-1:DWORD_LSB] == OFS_STREAM_SRC[ADDR_W-1:DWORD_LSB]) begin
        rd_val[BT_RDY] = st_ff.src_rdy;
        rd_val[BT_C] = st_ff.src_c;
        rd_val[BT_PA_LSB +: BT_PA_W] = st_ff.src_addr;
        if (BUS.we) begin
          nxt_st.src_c = BUS.wdata[BT_C];
          nxt_st.src_addr = BUS.wdata[BT_PA_LSB +: BT_PA_W];
          nxt_st.src_rdy = 1'b0;
          nxt_st.rd_req = 1'b1;
        end
      end else if (BUS.addr[ADDR_W-1:DWORD_LSB] == OFS_STREAM_DST[ADDR_W-1:DWORD_LSB]) begin
        rd_val[BT_RDY] = st_ff.dst_rdy;
        rd_val[BT_C] = st_ff.dst_c;
        rd_val[BT_PA_LSB +: BT_PA_W] = st_ff.dst_addr;
        if (BUS.we) begin
          nxt_st.dst_c = BUS.wdata[BT_C];
          nxt_st.dst_addr = BUS.wdata[BT_PA_LSB +: BT_PA_W];
          nxt_st.dst_rdy = 1'b0;
          nxt_st.wr_req = 1'b1;
        end
      end else if (BUS.addr[ADDR_W-1:DWORD_LSB] == OFS_COUNTERS[ADDR_W-1:DWORD_LSB]) begin
        rd_val = {st_ff.miss_count, st_ff.ref_count};
        if (BUS.we) begin
          // software write wins over a same-cycle count so a zero store clears
          {nxt_st.miss_count, nxt_st.ref_count} = BUS.wdata;
        end
      end else if (BUS.addr[ADDR_W-1:DWORD_LSB] == OFS_SELF_TEST[ADDR_W-1:DWORD_LSB]) begin
        rd_val[SIG_W-1:0] = st_ff.signature;
        if (BUS.we) begin
          nxt_st.ack = 1'b0;
          nxt_st.self_test_busy = 1'b1;
          nxt_st.self_test_cnt = 32'(SELF_TEST_LEN - 1);
          nxt_st.signature = '1;
        end
      end else if (BUS.addr[ADDR_W-1:DWORD_LSB] == OFS_CONTROL[ADDR_W-1:DWORD_LSB]) begin
        rd_val[CTL_RC] = st_ff.read_only_counting;
        rd_val[CTL_PF] = st_ff.prefetch_enable;
        rd_val[CTL_MC] = st_ff.multi_command_enable;
        rd_val[CTL_PE] = st_ff.parity_even_check;
        rd_val[CTL_CE] = st_ff.cache_enable;
        if (BUS.we) begin
          nxt_st.read_only_counting = BUS.wdata[CTL_RC];
          nxt_st.prefetch_enable = BUS.wdata[CTL_PF];
          nxt_st.multi_command_enable = BUS.wdata[CTL_MC];
          nxt_st.parity_even_check = BUS.wdata[CTL_PE];
          nxt_st.cache_enable = BUS.wdata[CTL_CE];
        end
      end else if (BUS.addr[ADDR_W-1:DWORD_LSB] == OFS_STATUS[ADDR_W-1:DWORD_LSB]) begin
        rd_val[ST_SXP] = STORE_EXCEPTION_PENDING;
        rd_val[ST_SM] = SYNCHRONOUS_SPEED;
        rd_val[ST_NCS_LSB +: PEND_W] = NONCACHE_STORE_PENDING_COUNT;
        rd_val[ST_SPC_LSB +: PEND_W] = STORE_PENDING_COUNT;
        rd_val[ST_WP] = WRITE_MISS_PENDING;
        rd_val[ST_RP] = READ_MISS_PENDING;
        rd_val[ST_PP] = st_ff.pf_pend;
      end else if (BUS.addr[ADDR_W-1:DWORD_LSB] == OFS_RESET[ADDR_W-1:DWORD_LSB]) begin
        rd_val[RST_WD] = st_ff.watchdog_reset_flag;
        rd_val[RST_SI] = st_ff.soft_reset;
        if (BUS.we) begin
          nxt_st.soft_reset = BUS.wdata[RST_SI];
          if (BUS.wdata[RST_WD]) begin
            nxt_st.watchdog_reset_flag = 1'b0;
          end
        end
      end else if (BUS.addr[ADDR_W-1:DWORD_LSB] == OFS_ERROR[ADDR_W-1:DWORD_LSB]) begin
        rd_val[ER_ME] = st_ff.multiple_error;
        rd_val[ER_CC] = st_ff.consistency_error;
        rd_val[ER_VP] = st_ff.master_write_parity_error;
        rd_val[ER_CP] = st_ff.read_parity_error;
        rd_val[ER_AE] = st_ff.asynchronous_error;
        rd_val[ER_EV] = st_ff.error_valid;
        rd_val[ER_OP_LSB +: OP_W] = st_ff.operation_code;
        rd_val[ER_CODE_LSB +: CODE_W] = st_ff.err_code;
        rd_val[ER_S] = st_ff.err_super;
        rd_val[PA_W-1:0] = st_ff.err_addr;
        if (BUS.we) begin
          // clearing only what was written back keeps errors posted since the read
          if (BUS.wdata[ER_ME]) nxt_st.multiple_error = 1'b0;
          if (BUS.wdata[ER_CC]) nxt_st.consistency_error = 1'b0;
          if (BUS.wdata[ER_VP]) nxt_st.master_write_parity_error = 1'b0;
          if (BUS.wdata[ER_CP]) nxt_st.read_parity_error = 1'b0;
          if (BUS.wdata[ER_AE]) nxt_st.asynchronous_error = 1'b0;
          if (BUS.wdata[ER_EV]) nxt_st.error_valid = 1'b0;
        end
      end else if (BUS.addr[ADDR_W-1:DWORD_LSB] == OFS_IDENT[ADDR_W-1:DWORD_LSB]) begin
        rd_val[ID_MID_LSB +: MID_W] = MODULE_ID;
        rd_val[ID_DEV_LSB +: 8] = DEVICE_NUMBER;
        rd_val[ID_REV_LSB +: 4] = REVISION_NUMBER;
        rd_val[3:0] = VENDOR_NUMBER;
      end
      if (!BUS.we) begin
        nxt_st.rdata = rd_val;
      end
    end

    // error posting after the release write: a set in the clear cycle wins
    if (WATCHDOG_RESET) nxt_st.watchdog_reset_flag = 1'b1;
    if ((CONSISTENCY_ERROR && st_ff.consistency_error)
        || (MASTER_WRITE_PARITY_ERROR && st_ff.master_write_parity_error)
        || (cp_in && st_ff.read_parity_error)
        || (ASYNCHRONOUS_ERROR && st_ff.asynchronous_error)) begin
      nxt_st.multiple_error = 1'b1;
    end
    if (CONSISTENCY_ERROR) nxt_st.consistency_error = 1'b1;
    if (cp_in) nxt_st.read_parity_error = 1'b1;
    if (ASYNCHRONOUS_ERROR) nxt_st.asynchronous_error = 1'b1;
    if (MASTER_WRITE_PARITY_ERROR) begin
      nxt_st.master_write_parity_error = 1'b1;
      nxt_st.sync_fault_status_vp = 1'b1;
      nxt_st.sync_fault_address = ERR_ADDR;
    end
    if ((CONSISTENCY_ERROR || cp_in || ASYNCHRONOUS_ERROR) && !nxt_st.error_valid) begin
      nxt_st.error_valid = 1'b1;
      nxt_st.err_super = ERR_SUPERVISOR;
      // consistency, read parity and asynchronous errors share one detail port; only the code field differs
      nxt_st.operation_code = ERR_OPERATION_CODE;
      nxt_st.err_addr = ERR_ADDR;
      nxt_st.err_code = '0;
      if (ASYNCHRONOUS_ERROR) begin
        nxt_st.err_code = {{(CODE_W-ACK_W){1'b0}}, ERR_BUS_ACK};
      end else if (cp_in) begin
        nxt_st.err_code = syndrome;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff <= '0;
      st_ff.multi_command_enable <= CTL_MC_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign BUS.ack = st_ff.ack;
  assign BUS.rdata = st_ff.rdata;
  assign STREAM_READ_REQ = st_ff.rd_req;
  assign STREAM_WRITE_REQ = st_ff.wr_req;
  assign STREAM_SRC_ADDR = st_ff.src_addr;
  assign STREAM_SRC_CACHEABLE = st_ff.src_c;
  assign STREAM_DST_ADDR = st_ff.dst_addr;
  assign STREAM_DST_CACHEABLE = st_ff.dst_c;
  assign STREAM_BLOCK = st_ff.blk;
  assign PREFETCH_REQ = st_ff.pf_req;
  assign PREFETCH_ADDR = st_ff.pf_addr;
  assign READ_ONLY_COUNTING = st_ff.read_only_counting;
  assign PREFETCH_ENABLE = st_ff.prefetch_enable;
  assign MULTI_COMMAND_ENABLE = st_ff.multi_command_enable;
  assign PARITY_EVEN_CHECK = st_ff.parity_even_check;
  assign CACHE_ENABLE = st_ff.cache_enable;
  assign WR_PARITY = st_ff.wr_par;
  assign SOFT_RESET = st_ff.soft_reset;
  assign MODULE_ERROR = st_ff.consistency_error | st_ff.master_write_parity_error
                      | st_ff.read_parity_error | st_ff.asynchronous_error
                      | st_ff.watchdog_reset_flag;
  assign SYNC_FAULT_STATUS = {{(SYNC_FAULT_STATUS_W-SYNC_FAULT_STATUS_VP-1){1'b0}}, st_ff.sync_fault_status_vp, {SYNC_FAULT_STATUS_VP{1'b0}}};
  assign SYNC_FAULT_ADDRESS = st_ff.sync_fault_address;
endmodule
`default_nettype wire

// >>> rtl/ecr_host.sv
`timescale 1ns/1ps
`default_nettype none
module ecr_host (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  ecr_bus_if.host BUS,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_WRITE,
  input wire logic [ecr_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [ecr_pkg::DATA_W-1:0] CMD_WDATA,
  output logic RSP_VALID,
  output logic [ecr_pkg::DATA_W-1:0] RSP_RDATA
);
  import ecr_pkg::*;

  typedef struct packed {
    ecr_host_e state;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_rdata;
  } ecr_host_s;

  ecr_host_s st_ff;
  ecr_host_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp_valid = 1'b0;
    case (st_ff.state)
      ECR_IDLE: begin
        if (CMD_VALID) begin
          nxt_st.state = ECR_WAIT;
          nxt_st.we = CMD_WRITE;
          // only whole aligned double-words go out
          nxt_st.addr = {CMD_ADDR[ADDR_W-1:DWORD_LSB], {DWORD_LSB{1'b0}}};
          nxt_st.wdata = CMD_WDATA;
        end
      end
      ECR_WAIT: begin
        // no timeout: a self-test write is answered only when it ends
        if (BUS.ack) begin
          nxt_st.state = ECR_IDLE;
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_rdata = st_ff.we ? st_ff.rsp_rdata : BUS.rdata;
        end
      end
      default: nxt_st.state = ECR_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign CMD_READY = (st_ff.state == ECR_IDLE);
  assign BUS.req = (st_ff.state == ECR_WAIT);
  assign BUS.we = st_ff.we;
  assign BUS.addr = st_ff.addr;
  assign BUS.wdata = st_ff.wdata;
  assign RSP_VALID = st_ff.rsp_valid;
  assign RSP_RDATA = st_ff.rsp_rdata;
endmodule
`default_nettype wire

// >>> bench/ecr_bus_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ecr_bus_asserts
  import ecr_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic req,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic ack
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_rd(logic [31:0] ofs);
    ack && !we && addr == ofs;
  endsequence
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; ack |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
  property p_req_hold; req && !ack |=> req && $stable(addr) && $stable(we); endproperty
  a_req_hold: assert property (p_req_hold) else $error("req dropped early");
  // self-test holds the answer back, so the bound covers the shortened test length
  property p_ack_bound; $rose(req) |-> ##[1:12] ack; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("no ack");
  property p_ctl; s_rd(OFS_CONTROL) |-> rdata[63:10] == 0 && rdata[8:6] == 0 && rdata[1:0] == 0;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control reserved set");
  property p_rst; s_rd(OFS_RESET) |-> rdata[63:3] == 0 && !rdata[0]; endproperty
  a_rst: assert property (p_rst) else $error("reset reserved set");
  property p_st; s_rd(OFS_STATUS) |-> rdata[63:40] == 0 && rdata[37:12] == 0 && !rdata[3];
  endproperty
  a_st: assert property (p_st) else $error("status reserved set");
  property p_id; s_rd(OFS_IDENT) |-> rdata[63:28] == 0 && rdata[23:16] == 0; endproperty
  a_id: assert property (p_id) else $error("identity reserved set");
  property p_bt; s_rd(OFS_STREAM_SRC) or s_rd(OFS_STREAM_DST) |-> rdata[62:37] == 0 && rdata[4:0] == 0;
  endproperty
  a_bt: assert property (p_bt) else $error("transfer reserved set");
endmodule
`default_nettype wire

// >>> bench/ecache_controller_reg_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ecache_controller_reg_bank_tb;
  import ecr_pkg::*;
  logic SYS_CLK = 0, RST_B = 0, CMD_VALID = 0, CMD_WRITE = 0, STREAM_FILL_VALID = 0,
    STREAM_READ_DONE = 0, STREAM_WRITE_DONE = 0, CACHE_REF = 0, CACHE_MISS = 0, REF_IS_READ = 0,
    BURST_READ_MISS = 0, NEXT_SUBBLK_PRESENT = 0, PREFETCH_DONE = 0, RD_VALID = 0,
    STORE_EXCEPTION_PENDING = 0, SYNCHRONOUS_SPEED = 0, WRITE_MISS_PENDING = 0,
    READ_MISS_PENDING = 0, WATCHDOG_RESET = 0, CONSISTENCY_ERROR = 0, ERR_SUPERVISOR = 0,
    MASTER_WRITE_PARITY_ERROR = 0, ASYNCHRONOUS_ERROR = 0;
  logic CMD_READY, RSP_VALID, STREAM_READ_REQ, STREAM_WRITE_REQ, STREAM_SRC_CACHEABLE,
    STREAM_DST_CACHEABLE, PREFETCH_REQ, READ_ONLY_COUNTING, PREFETCH_ENABLE, MODULE_ERROR,
    MULTI_COMMAND_ENABLE, PARITY_EVEN_CHECK, CACHE_ENABLE, SOFT_RESET;
  logic [1:0] STREAM_FILL_INDEX = 0;
  logic [2:0] ERR_BUS_ACK = 0;
  logic [3:0] NONCACHE_STORE_PENDING_COUNT = 0, STORE_PENDING_COUNT = 0, MODULE_ID = 0;
  logic [7:0] RD_PARITY = 0, WR_PARITY;
  logic [9:0] ERR_OPERATION_CODE = 0;
  logic [30:0] MISS_SUBBLK_ADDR = 0, STREAM_SRC_ADDR, STREAM_DST_ADDR, PREFETCH_ADDR;
  logic [31:0] CMD_ADDR = 0, SYNC_FAULT_STATUS, cm, cr;
  logic [35:0] ERR_ADDR = 0, SYNC_FAULT_ADDRESS;
  logic [63:0] STREAM_FILL_DATA = 0, WR_DATA = 0, RD_DATA = 0, CMD_WDATA = 0, RSP_RDATA, rd, e;
  logic [255:0] STREAM_BLOCK;
  int errors = 0, checks_done = 0, n;
  ecr_bus_if BUS ();
  ecr_host u_ecr_host (.*);
  ecr_dev #(.SELF_TEST_LEN(8)) u_ecr_dev (.*);
  ecr_bus_asserts u_ecr_bus_asserts (.SYS_CLK, .RST_B, .req(BUS.req), .we(BUS.we),
    .addr(BUS.addr), .rdata(BUS.rdata), .ack(BUS.ack));
  initial forever #12.5 SYS_CLK = ~SYS_CLK;
  task automatic complete_run;
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one command at a time; the response pulse is caught at a falling edge
  task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
    @(negedge SYS_CLK);
    {CMD_VALID, CMD_WRITE, CMD_ADDR, CMD_WDATA} = {1'b1, w, a, d};
    @(negedge SYS_CLK);
    CMD_VALID = 0;
    for (n = 0; n < 40 && RSP_VALID !== 1'b1; n++) @(negedge SYS_CLK);
    if (n == 40) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      complete_run;
    end
    rd = RSP_RDATA;
  endtask
  task automatic pulse(ref logic s);
    @(negedge SYS_CLK);
    s = 1;
    @(negedge SYS_CLK);
    s = 0;
  endtask
  function automatic logic [7:0] par(input logic [63:0] d, input logic ev);
    for (int i = 0; i < 8; i++) par[i] = ^d[i*8 +: 8] ^ ~ev;
  endfunction
  initial begin
    void'($urandom(52));
    MODULE_ID = 4'($urandom);
    repeat (12) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    RST_B = 1;
    acc(0, OFS_CONTROL, 0);
    chk(rd, 64'h0000_0000_0000_0010);
    acc(0, OFS_IDENT, 0);
    chk(rd, {36'h0, MODULE_ID, 24'h00_3C7A});
    acc(1, 32'h01C0_0400, '1);
    acc(0, 32'h01C0_0400, 0);
    chk(rd, 0);
    for (int k = 1; k >= 0; k--) begin
      acc(1, OFS_CONTROL, k ? '1 : 64'h0000_0000_0000_0234);
      WR_DATA = {$urandom, $urandom};
      @(negedge SYS_CLK);
      chk(WR_PARITY, par(WR_DATA, k[0]));
    end
    chk({READ_ONLY_COUNTING, PREFETCH_ENABLE, MULTI_COMMAND_ENABLE, CACHE_ENABLE}, 4'hF);
    for (int k = 0; k < 2; k++) begin
      acc(1, OFS_CONTROL, {54'h0, k[0], 9'h018});
      acc(1, OFS_COUNTERS, 0);
      {cm, cr} = 0;
      repeat (20) begin
        @(negedge SYS_CLK);
        {REF_IS_READ, CACHE_MISS} = 2'($urandom);
        CACHE_REF = 1;
        if (k == 0 || REF_IS_READ) {cm, cr} = {cm + CACHE_MISS, cr + 1};
      end
      @(negedge SYS_CLK);
      {CACHE_REF, CACHE_MISS, REF_IS_READ} = 3'b001;
      acc(0, OFS_COUNTERS, 0);
      chk(rd, {cm, cr});
    end
    // two back-to-back missing references: the first sets bit 31, the second must be frozen out
    acc(1, OFS_COUNTERS, 64'h0000_0005_7FFF_FFFF);
    {CACHE_REF, CACHE_MISS} = 2'b11;
    repeat (2) @(negedge SYS_CLK);
    {CACHE_REF, CACHE_MISS} = 0;
    acc(0, OFS_COUNTERS, 0);
    chk(rd, 64'h0000_0006_8000_0000);
    {STORE_EXCEPTION_PENDING, SYNCHRONOUS_SPEED, NONCACHE_STORE_PENDING_COUNT,
      STORE_PENDING_COUNT, WRITE_MISS_PENDING, READ_MISS_PENDING} = 12'($urandom);
    acc(0, OFS_STATUS, 0);
    chk(rd, {24'h0, STORE_EXCEPTION_PENDING, SYNCHRONOUS_SPEED, 26'h0, NONCACHE_STORE_PENDING_COUNT,
      STORE_PENDING_COUNT, 1'b0, WRITE_MISS_PENDING, READ_MISS_PENDING, 1'b0});
    pulse(WATCHDOG_RESET);
    acc(0, OFS_RESET, 0);
    chk({rd[62:0], MODULE_ERROR}, 64'h9);
    acc(1, OFS_RESET, '1);
    acc(0, OFS_RESET, 0);
    chk({rd[61:0], MODULE_ERROR, SOFT_RESET}, 64'h9);
    acc(1, OFS_RESET, 0);
    ERR_BUS_ACK = 3'($urandom % 4 + 1);
    {ERR_OPERATION_CODE, ERR_SUPERVISOR, ERR_ADDR} = 47'({$urandom, $urandom});
    e = {7'b0000011, ERR_OPERATION_CODE, 5'h0, ERR_BUS_ACK, ERR_SUPERVISOR, 2'b0, ERR_ADDR};
    pulse(ASYNCHRONOUS_ERROR);
    ERR_ADDR = ~ERR_ADDR;
    repeat (2) pulse(CONSISTENCY_ERROR);
    acc(0, OFS_ERROR, 0);
    chk(rd & ~(64'h1F << 42), e | 64'hA000_0000_0000_0000);
    pulse(MASTER_WRITE_PARITY_ERROR);
    chk(SYNC_FAULT_STATUS, 64'h2000);
    chk(SYNC_FAULT_ADDRESS, ERR_ADDR);
    acc(0, OFS_ERROR, 0);
    acc(1, OFS_ERROR, rd);
    acc(0, OFS_ERROR, 0);
    chk({rd[63:57], MODULE_ERROR}, 0);
    pulse(ASYNCHRONOUS_ERROR);
    acc(0, OFS_ERROR, 0);
    chk(rd[57:47], {1'b1, ERR_OPERATION_CODE});
    pulse(CONSISTENCY_ERROR);
    acc(1, OFS_ERROR, rd);
    acc(0, OFS_ERROR, 0);
    chk({rd[63:57], MODULE_ERROR}, 8'h21);
    acc(1, OFS_ERROR, rd);
    RD_DATA = {$urandom, $urandom};
    cr = $urandom | 1;
    RD_PARITY = par(RD_DATA, 1) ^ cr[7:0];
    pulse(RD_VALID);
    acc(0, OFS_ERROR, 0);
    chk({rd[59], rd[46:39]}, {1'b1, cr[7:0]});
    acc(1, OFS_ERROR, rd);
    acc(1, OFS_STREAM_SRC, {1'b1, 26'h3FF_FFFF, 1'b1, cr[30:0], 5'h1F});
    acc(0, OFS_STREAM_SRC, 0);
    chk(rd, {27'h0, 1'b1, cr[30:0], 5'h0});
    chk(STREAM_SRC_ADDR, cr[30:0]);
    pulse(STREAM_READ_DONE);
    acc(0, OFS_STREAM_SRC, 0);
    chk(rd[63], 1);
    acc(1, OFS_STREAM_DST, {28'h0, ~cr[30:0], 5'h0});
    chk({STREAM_DST_CACHEABLE, STREAM_DST_ADDR}, {1'b0, ~cr[30:0]});
    pulse(STREAM_WRITE_DONE);
    acc(0, OFS_STREAM_DST, 0);
    chk(rd, {1'b1, 27'h0, ~cr[30:0], 5'h0});
    for (int i = 0; i < 4; i++) begin
      e = {$urandom, $urandom};
      acc(1, OFS_STREAM_DATA | 32'(i << 3), e);
      chk(STREAM_BLOCK[i*64 +: 64], e);
    end
    STREAM_FILL_INDEX = 2'($urandom);
    STREAM_FILL_DATA = {$urandom, $urandom};
    pulse(STREAM_FILL_VALID);
    acc(0, OFS_STREAM_DATA | (32'(STREAM_FILL_INDEX) << 3), 0);
    chk(rd, STREAM_FILL_DATA);
    acc(1, OFS_CONTROL, 64'h0000_0000_0000_0038);
    for (int i = 2; i < 4; i++) begin
      MISS_SUBBLK_ADDR = {cr[30:2], i[1:0]};
      pulse(BURST_READ_MISS);
      chk(PREFETCH_REQ, 64'(i == 2));
      if (i == 2) chk(PREFETCH_ADDR, {cr[30:2], 2'd3});
      pulse(PREFETCH_DONE);
    end
    acc(1, OFS_SELF_TEST, 0);
    chk(n > 7, 1);
    acc(0, OFS_SELF_TEST, 0);
    chk(rd[63:32], 0);
    complete_run;
  end
endmodule
`default_nettype wire
